// [design/cpc_pkg.sv]
// Constants and types for the command/address parity checker
package cpc_pkg;

   // ------------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------------
   localparam int ADDR_W     = 14;
   localparam int STACK_W    = 3;
   localparam int FRAME_W    = 22;   // act, ras, cas, we, bg, ba, addr
   localparam int LOG_W      = 23;   // frame plus parity input
   localparam int DLY_DEPTH  = 8;
   localparam int TAP_W      = 3;
   localparam int LAT_W      = 4;
   localparam int CODE_W     = 3;
   localparam int CL_W       = 5;
   localparam int RWL_W      = 7;
   localparam int CNT_W      = 8;

   // ------------------------------------------------------------------
   // Parity latency codes and their clock counts
   // ------------------------------------------------------------------
   localparam logic [CODE_W-1:0] LAT_CODE_4 = 3'h1;
   localparam logic [CODE_W-1:0] LAT_CODE_5 = 3'h2;
   localparam logic [CODE_W-1:0] LAT_CODE_6 = 3'h3;
   localparam logic [CODE_W-1:0] LAT_CODE_8 = 3'h4;
   localparam logic [LAT_W-1:0]  LAT_OFF    = 4'h0;
   localparam logic [LAT_W-1:0]  LAT_4      = 4'h4;
   localparam logic [LAT_W-1:0]  LAT_5      = 4'h5;
   localparam logic [LAT_W-1:0]  LAT_6      = 4'h6;
   localparam logic [LAT_W-1:0]  LAT_8      = 4'h8;

   // ------------------------------------------------------------------
   // Timing, in ns and in mclk cycles
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int T_RAS_MIN_NS    = 3200;
   localparam int T_PW_MIN_NS     = 4000;
   localparam int T_PW_MAX_NS     = 16000;
   // Least times round up, longest times round down
   localparam int RAS_CYC    = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int PW_MIN_CYC = (T_PW_MIN_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int PW_MAX_CYC = T_PW_MAX_NS / CLK_PERIOD_NS;

   localparam logic [CNT_W-1:0] RAS_END    = CNT_W'(RAS_CYC - 1);
   localparam logic [CNT_W-1:0] PW_MIN_END = CNT_W'(PW_MIN_CYC - 1);
   localparam logic [CNT_W-1:0] PW_MAX_END = CNT_W'(PW_MAX_CYC - 1);

   // ------------------------------------------------------------------
   // Error handling sequence
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CPC_RUN,
      CPC_DRAIN,
      CPC_ALERT,
      CPC_HOLD
   } cpc_state_t;

endpackage : cpc_pkg

// [design/cpc_delay.sv]
// Parity latency delay line for command frames
module cpc_delay
   import cpc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rstn,
   input  wire logic               clk_en,
   input  wire logic [FRAME_W-1:0] din,
   input  wire logic               vin,
   input  wire logic [TAP_W-1:0]   tap,
   output logic      [FRAME_W-1:0] dout,
   output logic                    vout
);

   logic [FRAME_W-1:0] dat_r [DLY_DEPTH];
   logic [DLY_DEPTH-1:0] vld_r;

   // ------------------------------------------------------------------
   // Shift stages
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < DLY_DEPTH; i++) begin : g_stage
         // Valid and data both cleared, so taps read zero until bus data shifts in
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               vld_r[i] <= 1'b0;
               dat_r[i] <= '0;
            end else if (clk_en) begin
               vld_r[i] <= (i == 0) ? vin : vld_r[(i == 0) ? 0 : i-1];
               dat_r[i] <= (i == 0) ? din : dat_r[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   // Tap selection
   assign dout = dat_r[tap];
   assign vout = vld_r[tap];

endmodule : cpc_delay

// [design/cpc_checker.sv]
// Command/address parity checker with latency, error log and alert
module cpc_checker
   import cpc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rstn,
   input  wire logic               clk_en,
   input  wire logic               cs_n,
   input  wire logic               act_n,
   input  wire logic               ras_n,
   input  wire logic               cas_n,
   input  wire logic               we_n,
   input  wire logic [1:0]         bg,
   input  wire logic [1:0]         ba,
   input  wire logic [ADDR_W-1:0]  addr,
   input  wire logic [STACK_W-1:0] stack_pins,
   input  wire logic               stack_en,
   input  wire logic               command_address_parity,
   input  wire logic [CODE_W-1:0]  lat_code,
   input  wire logic               persist_en,
   input  wire logic               status_wr,
   input  wire logic               status_wr_data,
   input  wire logic [CL_W-1:0]    add_lat,
   input  wire logic [CL_W-1:0]    cas_lat,
   input  wire logic [CL_W-1:0]    cas_wr_lat,
   output logic                    exec_valid_r,
   output logic      [FRAME_W-1:0] exec_cmd_r,
   output logic                    precharge_all_r,
   output logic                    alert_n_r,
   output logic                    err_status_r,
   output logic      [LOG_W-1:0]   err_log_r,
   output logic                    check_on_r,
   output logic      [LAT_W-1:0]   parity_latency_r,
   output logic      [RWL_W-1:0]   rd_lat_r,
   output logic      [RWL_W-1:0]   wr_lat_r
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   cpc_state_t         state_r;
   cpc_state_t         state_nxt;
   logic [CNT_W-1:0]   cnt_r;
   logic               pre_done_r;
   logic [FRAME_W-1:0] frame_w;
   logic [STACK_W-1:0] stack_w;
   logic               par_odd;
   logic               cmd_sel;
   logic               check_on;
   logic               err_det;
   logic               pl_on;
   logic [LAT_W-1:0]   lat_nxt;
   logic [TAP_W-1:0]   tap_w;
   logic [FRAME_W-1:0] dly_dat;
   logic               dly_vld;
   logic               exec_nxt;
   logic               status_nxt;
   logic               status_clr;
   logic               pre_fire;
   logic               release_ok;

   // ------------------------------------------------------------------
   // Frame capture and parity
   // ------------------------------------------------------------------
   // covered inputs only
   assign frame_w = {act_n, ras_n, cas_n, we_n, bg, ba, addr};
   // unused stacking pins forced to zero
   assign stack_w = stack_en ? stack_pins : '0;
   // even parity over frame, stack pins and parity bit
   assign par_odd = ^{frame_w, stack_w, command_address_parity};
   // parity judged on the edge the frame is sampled, cs low only
   assign cmd_sel = !cs_n;

   // Checking is live only with a latency programmed and, unless persistent, no error pending
   // nonzero latency arms the check
   // suspended while status set, unless persistent
   // persistent mode resumes at alert release
   assign pl_on    = (parity_latency_r != LAT_OFF);
   assign check_on = pl_on
                     && (state_r == CPC_RUN
                         || (state_r == CPC_HOLD && persist_en))
                     && (!err_status_r || persist_en);
   assign err_det  = cmd_sel && check_on && par_odd;

   // ------------------------------------------------------------------
   // Latency decode and command delay
   // ------------------------------------------------------------------
   // Reserved codes read as disabled; the controller must step via
   // disabled between two latencies, so no retiming of queued frames
   // relies on disabled step between latencies
   assign lat_nxt = (lat_code == LAT_CODE_4) ? LAT_4 :
                    (lat_code == LAT_CODE_5) ? LAT_5 :
                    (lat_code == LAT_CODE_6) ? LAT_6 :
                    (lat_code == LAT_CODE_8) ? LAT_8 : LAT_OFF;
   // Output register adds the last cycle of delay
   assign tap_w   = TAP_W'(parity_latency_r - 4'h1);

   // commands go through the latency pipe only when a latency is set
   cpc_delay u_delay (
      .mclk   (mclk),
      .rstn   (rstn),
      .clk_en (clk_en),
      .din    (frame_w),
      .vin    (cmd_sel && !err_det),
      .tap    (tap_w),
      .dout   (dly_dat),
      .vout   (dly_vld)
   );

   // Execution only in normal running; frames behind an error die here
   // failing frame never entered the pipe as valid
   // nothing executes during the alert window
   // a dropped read never issues, so strobes stay undriven
   assign exec_nxt = (state_r == CPC_RUN)
                     && (pl_on ? dly_vld : cmd_sel);

   // ------------------------------------------------------------------
   // Error handling sequence
   // ------------------------------------------------------------------
   assign pre_fire   = (state_r == CPC_DRAIN) && (cnt_r == RAS_END);
   assign release_ok = (state_r == CPC_ALERT) && (cnt_r >= PW_MIN_END)
                       && pre_done_r;

   // Next state; a new error always restarts the sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CPC_RUN:   state_nxt = state_r;
         CPC_DRAIN: if (pre_fire) state_nxt = CPC_ALERT;
         CPC_ALERT: if (release_ok) state_nxt = CPC_HOLD;
         CPC_HOLD:  if (cnt_r >= PW_MAX_END) state_nxt = CPC_RUN;
         default:   state_nxt = CPC_RUN;
      endcase
      if (err_det) state_nxt = CPC_DRAIN;
   end

   // Sequence state, window counter and precharge bookkeeping
   // wait row time, then precharge all once
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_r         <= CPC_RUN;
         cnt_r           <= '0;
         pre_done_r      <= 1'b0;
         precharge_all_r <= 1'b0;
      end else if (clk_en) begin
         state_r         <= state_nxt;
         cnt_r           <= err_det ? '0 : cnt_r + 8'h01;
         pre_done_r      <= !err_det && (pre_done_r || pre_fire);
         precharge_all_r <= pre_fire;
      end
   end

   // ------------------------------------------------------------------
   // Alert pin, status bit and error log
   // ------------------------------------------------------------------
   // only a zero write clears; a one write is ignored
   assign status_clr = status_wr && !status_wr_data;
   // a fresh error wins over a simultaneous clear
   assign status_nxt = err_det || (err_status_r && !status_clr);

   // alert low on the edge after detection
   // release assumes the controller sends deselects around it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         alert_n_r    <= 1'b1;
         err_status_r <= 1'b0;
      end else if (clk_en) begin
         alert_n_r    <= !(err_det || state_nxt == CPC_DRAIN
                           || state_nxt == CPC_ALERT);
         err_status_r <= status_nxt;
      end
   end

   // every frame that fails while checking is on overwrites the log
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         err_log_r <= '0;
      end else if (clk_en && err_det) begin
         err_log_r <= {frame_w, command_address_parity};
      end
   end

   // ------------------------------------------------------------------
   // Command output and latency reporting
   // ------------------------------------------------------------------
   // read and write latency grow by the parity latency
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         exec_valid_r     <= 1'b0;
         exec_cmd_r       <= '0;
         check_on_r       <= 1'b0;
         parity_latency_r <= LAT_OFF;
         rd_lat_r         <= '0;
         wr_lat_r         <= '0;
      end else if (clk_en) begin
         exec_valid_r     <= exec_nxt;
         exec_cmd_r       <= pl_on ? dly_dat : frame_w;
         check_on_r       <= check_on;
         parity_latency_r <= lat_nxt;
         rd_lat_r         <= RWL_W'(add_lat) + RWL_W'(cas_lat)
                             + RWL_W'(parity_latency_r);
         wr_lat_r         <= RWL_W'(add_lat) + RWL_W'(cas_wr_lat)
                             + RWL_W'(parity_latency_r);
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   localparam int HOLD_LO = 1;
   localparam int HOLD_HI = 300;

   sequence err_then_low;
      err_det ##1 !alert_n_r;
   endsequence

   sequence quiet_alert;
      (!exec_valid_r && !alert_n_r) [*4];
   endsequence

   // odd frame while checking raises the alert
   parity_bad_a : assert property (@(posedge mclk) disable iff (!rstn)
      (clk_en && cmd_sel && check_on && par_odd) |=> !alert_n_r)
      else $error("odd parity did not raise alert");
   alert_on_a : assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && err_det |-> err_then_low)
      else $error("alert not driven low");
   quiet_window_a : assert property (@(posedge mclk) disable iff (!rstn)
      (clk_en && err_det) ##1 clk_en [*4] |-> ##1 quiet_alert)
      else $error("command executed in alert window");
   // status set before alert can rise
   status_set_a : assert property (@(posedge mclk) disable iff (!rstn)
      $rose(alert_n_r) |-> err_status_r)
      else $error("status bit not set at release");
   // release only after min width and precharge
   release_min_a : assert property (@(posedge mclk) disable iff (!rstn)
      $rose(alert_n_r) |-> $past(pre_done_r)
      && $past(cnt_r) >= PW_MIN_END)
      else $error("alert released early");
   log_frame_a : assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && err_det |=> err_log_r == {$past(frame_w),
      $past(command_address_parity)})
      else $error("error log wrong");
   // zero write clears, absent a new error
   status_clr_a : assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && status_clr && !err_det |=> !err_status_r)
      else $error("status not cleared");
   // one write never sets the bit
   status_one_a : assert property (@(posedge mclk) disable iff (!rstn)
      clk_en && !err_status_r && !err_det |=> !err_status_r)
      else $error("status set without error");
   // no checking while status pending outside persistent mode
   suspend_chk_a : assert property (@(posedge mclk) disable iff (!rstn)
      (clk_en && state_r == CPC_RUN && err_status_r && !persist_en
      && cmd_sel) |=> alert_n_r)
      else $error("checking not suspended");
   // latency four shows at the output exactly five edges after the frame
   pipe_four_a : assert property (@(posedge mclk) disable iff (!rstn)
      (clk_en [*6]) ##0 (exec_valid_r && parity_latency_r == LAT_4
      && $past(parity_latency_r, 5) == LAT_4) |-> $past(cmd_sel, 5))
      else $error("latency pipe misaligned");
   rd_lat_a : assert property (@(posedge mclk) disable iff (!rstn)
      clk_en |=> rd_lat_r == RWL_W'($past(add_lat)) + RWL_W'(
      $past(cas_lat)) + RWL_W'($past(parity_latency_r)))
      else $error("read latency sum wrong");
   // returns to running within 300 cycles of release
   resume_a : assert property (@(posedge mclk) disable iff (!rstn)
      $rose(alert_n_r) && clk_en |-> ##[HOLD_LO:HOLD_HI]
      (state_r == CPC_RUN || !alert_n_r))
      else $error("did not resume after alert");

endmodule : cpc_checker

// [sim/cpc_host_model.sv]
// Memory controller model driving the command/address bus
module cpc_host_model
   import cpc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               stack_en,
   output logic                    cs_n,
   output logic                    act_n,
   output logic                    ras_n,
   output logic                    cas_n,
   output logic                    we_n,
   output logic      [1:0]         bg,
   output logic      [1:0]         ba,
   output logic      [ADDR_W-1:0]  addr,
   output logic      [STACK_W-1:0] stack_pins,
   output logic                    command_address_parity
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus is a deselect with no frame
   initial begin
      cs_n = 1'b1;
      {act_n, ras_n, cas_n, we_n, bg, ba, addr} = '0;
      stack_pins = '0;
      command_address_parity = 1'b0;
   end

   // One selected frame, then back to deselect
   task automatic send(input logic [FRAME_W-1:0] f,
                       input logic [STACK_W-1:0] stk,
                       input logic               bad);
      cs_n = 1'b0;
      {act_n, ras_n, cas_n, we_n, bg, ba, addr} = f;
      stack_pins = stk;
      // even ones, stack pins only when used
      command_address_parity = (^f) ^ (stack_en & (^stk)) ^ bad;
      @(posedge mclk);
      #10;
      // only deselects follow; dead lines flip
      cs_n = 1'b1;
      {act_n, ras_n, cas_n, we_n, bg, ba, addr} = ~f;
      stack_pins = ~stk;
      command_address_parity = ~command_address_parity;
   endtask : send
endmodule : cpc_host_model

// [sim/cpc_checker_test.sv]
// Self-checking bench for the command/address parity checker
module cpc_checker_test
   import cpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              mclk           = 1'b0;
   logic              rstn           = 1'b0;
   logic              clk_en         = 1'b1;
   logic [CODE_W-1:0] lat_code       = 3'h0;
   logic              persist_en     = 1'b0;
   logic              status_wr      = 1'b0;
   logic              status_wr_data = 1'b0;
   logic [CL_W-1:0]   add_lat        = 5'h02;
   logic [CL_W-1:0]   cas_lat        = 5'h0B;
   logic [CL_W-1:0]   cas_wr_lat     = 5'h09;
   logic              stack_en       = 1'b0;
   logic              cs_n, act_n, ras_n, cas_n, we_n, command_address_parity;
   logic [1:0]        bg, ba;
   logic [ADDR_W-1:0] addr;
   logic [STACK_W-1:0] stack_pins;
   logic              exec_valid_r, precharge_all_r, alert_n_r;
   logic              err_status_r, check_on_r;
   logic [FRAME_W-1:0] exec_cmd_r;
   logic [LOG_W-1:0]  err_log_r;
   logic [LAT_W-1:0]  parity_latency_r;
   logic [RWL_W-1:0]  rd_lat_r, wr_lat_r;
   int                bad_count    = 0;
   int                total_checks = 0;

   always #50 mclk = ~mclk;

   cpc_host_model HOST (.mclk(mclk), .stack_en(stack_en), .cs_n(cs_n),
      .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg),
      .ba(ba), .addr(addr), .stack_pins(stack_pins),
      .command_address_parity(command_address_parity));

   cpc_checker DUT (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .cs_n(cs_n),
      .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg),
      .ba(ba), .addr(addr), .stack_pins(stack_pins), .stack_en(stack_en),
      .command_address_parity(command_address_parity),
      .lat_code(lat_code), .persist_en(persist_en), .status_wr(status_wr),
      .status_wr_data(status_wr_data), .add_lat(add_lat),
      .cas_lat(cas_lat), .cas_wr_lat(cas_wr_lat),
      .exec_valid_r(exec_valid_r), .exec_cmd_r(exec_cmd_r),
      .precharge_all_r(precharge_all_r), .alert_n_r(alert_n_r),
      .err_status_r(err_status_r), .err_log_r(err_log_r),
      .check_on_r(check_on_r), .parity_latency_r(parity_latency_r),
      .rd_lat_r(rd_lat_r), .wr_lat_r(wr_lat_r));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // Inputs move 10 ns after the edge, outputs settled by then
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #10;
   endtask : tick

   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Latency is counted in edges from the drive; zero means dropped
   task automatic run_cmd(input logic [FRAME_W-1:0] f,
                          input logic [STACK_W-1:0] stk, input logic bad,
                          input int exp_lat);
      int lat;
      int hits;
      lat = 0;
      hits = 0;
      HOST.send(f, stk, bad);
      for (int i = 1; i <= 12; i++) begin
         if (exec_valid_r === 1'b1) begin
            hits++;
            if (lat == 0)
               lat = i;
            check("exec_cmd_r", exec_cmd_r, f);
         end
         check("alert_n_r idle", alert_n_r, 1'b1);
         tick(1);
      end
      check("exec latency", lat, exp_lat);
      check("exec pulses", hits, (exp_lat != 0));
   endtask : run_cmd

   task automatic set_lat(input logic [CODE_W-1:0] code);
      lat_code = 3'h0;
      tick(2);
      lat_code = code;
      tick(3);
   endtask : set_lat

   task automatic write_status(input logic d);
      status_wr = 1'b1;
      status_wr_data = d;
      tick(1);
      status_wr = 1'b0;
      tick(1);
   endtask : write_status

   // Bad frame, then watch the whole recovery sequence
   task automatic error_seq(input logic [FRAME_W-1:0] f);
      int rise;
      int pre_at;
      int pre_n;
      int runs;
      rise = 0;
      pre_at = 0;
      pre_n = 0;
      runs = 0;
      HOST.send(f, 3'h0, 1'b1);
      check("alert_n_r", alert_n_r, 1'b0);
      check("err_status_r", err_status_r, 1'b1);
      check("err_log_r", err_log_r, {f, ~^f});
      for (int i = 1; i <= PW_MAX_CYC + 3; i++) begin
         if (precharge_all_r === 1'b1) begin
            pre_n++;
            pre_at = i;
         end
         if (exec_valid_r === 1'b1)
            runs++;
         // Checking state one edge into the hold
         if (rise != 0 && i == rise + 1)
            check("check in hold", check_on_r, persist_en);
         if (rise == 0 && alert_n_r === 1'b1) begin
            rise = i;
            check("status at release", err_status_r, 1'b1);
         end
         tick(1);
      end
      check("precharge pulses", pre_n, 1);
      check("precharge wait", (pre_at - 1 >= RAS_CYC), 1'b1);
      check("alert min width", (rise - 1 >= PW_MIN_CYC), 1'b1);
      check("alert max width", (rise - 1 <= PW_MAX_CYC), 1'b1);
      check("precharge first", (pre_at < rise), 1'b1);
      check("no execution", runs, 0);
   endtask : error_seq

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check("alert_n_r", alert_n_r, 1'b1);
      check("err_status_r", err_status_r, 1'b0);
      check("check_on_r", check_on_r, 1'b0);
      check("parity_latency_r", parity_latency_r, LAT_OFF);
      check("err_log_r", err_log_r, 0);
      $display("Test reset done");
   endtask : t_reset

   task automatic t_no_parity();
      // Frozen clock enable: a frame on the pins is never taken
      clk_en = 1'b0;
      HOST.send(22'h0F0F0F, 3'h0, 1'b0);
      check("frozen exec", exec_valid_r, 1'b0);
      tick(2);
      clk_en = 1'b1;
      run_cmd(22'h155555, 3'h0, 1'b1, 1);
      $display("Test no parity done");
   endtask : t_no_parity

   task automatic t_latencies();
      logic [CODE_W-1:0] codes [4];
      int                n [4];
      codes = '{LAT_CODE_4, LAT_CODE_5, LAT_CODE_6, LAT_CODE_8};
      n = '{4, 5, 6, 8};
      for (int i = 0; i < 4; i++) begin
         set_lat(codes[i]);
         check("parity_latency_r", parity_latency_r, n[i]);
         check("rd_lat_r", rd_lat_r, 2 + 11 + n[i]);
         check("wr_lat_r", wr_lat_r, 2 + 9 + n[i]);
         check("check_on_r", check_on_r, 1'b1);
         run_cmd(22'h2AAAAA ^ FRAME_W'(i), 3'h0, 1'b0, n[i] + 1);
      end
      $display("Test latencies done");
   endtask : t_latencies

   task automatic t_coverage();
      set_lat(LAT_CODE_5);
      for (int b = 0; b < FRAME_W; b++)
         run_cmd(FRAME_W'(1) << b, 3'h0, 1'b0, 6);
      stack_en = 1'b1;
      run_cmd(22'h000001, 3'h1, 1'b0, 6);
      stack_en = 1'b0;
      run_cmd(22'h000001, 3'h7, 1'b0, 6);
      $display("Test coverage done");
   endtask : t_coverage

   task automatic t_recover(input logic p);
      persist_en = p;
      set_lat(LAT_CODE_4);
      error_seq(22'h0A5C31);
      if (p) begin
         check("status kept", err_status_r, 1'b1);
         check("checking on", check_on_r, 1'b1);
         error_seq(22'h135AC2);
      end else begin
         check("checking off", check_on_r, 1'b0);
         run_cmd(22'h135AC2, 3'h0, 1'b1, 5);
         write_status(1'b0);
         check("status cleared", err_status_r, 1'b0);
         // A one written to the cleared bit must not set it
         write_status(1'b1);
         check("status write one", err_status_r, 1'b0);
         check("checking on", check_on_r, 1'b1);
         error_seq(22'h3C0FF0);
      end
      write_status(1'b0);
      persist_en = 1'b0;
      $display("Test recovery done");
   endtask : t_recover

   // Main sequence
   initial begin
      tick(8);
      rstn = 1'b1;
      tick(1);
      t_reset();
      t_no_parity();
      t_latencies();
      t_coverage();
      t_recover(1'b0);
      t_recover(1'b1);
      report_and_stop();
   end

   // Hang guard, about five times the expected run
   initial begin
      #(6000 * 100);
      bad_count++;
      $display("Error watchdog expired");
      report_and_stop();
   end
endmodule : cpc_checker_test
